// ==== hw/iq_demod_top.sv ====
// I/Q demodulator, decimator, lane mux and serializer with APB registers
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
module iq_demod_top #(
    parameter int MAX_M = 4                    // Largest decimation factor held
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic [iq_demod_pkg::NCH-1:0][iq_demod_pkg::SMP_W-1:0] adc_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [iq_demod_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    output logic      [31:0]                  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    output logic      [iq_demod_pkg::NCH-1:0] lane_o,
    output logic                              frame_clk_o,
    output logic                              bit_clk_o
);
    localparam int TAPS  = iq_demod_pkg::TAPS_PER_M * MAX_M;   // Delay line length
    localparam int NCOEF = iq_demod_pkg::COEFS_PER_M * MAX_M;  // Coefficient RAM depth

    // Factor field and 8-bit coefficient address limit the factor
    if (MAX_M < 1 || MAX_M > 32) begin : g_bad_max_m
        $error("MAX_M must lie in 1 to 32");
    end

    // Whole block state
    typedef struct packed {
        logic [13:0]                   ctrl;     // Bypass, power-down, factor
        logic [1:0][13:0]              dcofs;    // One offset per half
        logic [15:0]                   freq;     // Phase step
        logic [7:0]                    caddr;    // Coefficient pointer
        logic [NCOEF-1:0][13:0]        coef;     // Coefficient RAM
        logic [31:0]                   lmap;     // Four bits per lane
        logic                          pready;
        logic [31:0]                   prdata;
        logic                          pslverr;
        logic [15:0]                   phase;    // Mixer phase accumulator
        logic [1:0][7:0][TAPS-1:0][15:0] dly;    // Delay lines, I then Q
        logic [5:0]                    dcnt;     // Down-sampler slot count
        logic [1:0][7:0][15:0]         hold;     // Last kept filtered word
        logic [31:0]                   probe;    // Channel 1 down-sampler out
        logic [4:0]                    bcnt;     // Position within frame
        logic [7:0][15:0]              shreg;    // Words being serialized
        logic [7:0]                    lane;
        logic                          fclk;
        logic                          bclk;
    } state_t;

    state_t state_ff;                            // Registered state
    state_t nxt_state;                           // Next state

    // Sine from the top phase bits by quarter-wave folding
    function automatic logic signed [14:0] sin_of(input logic [15:0] p);
        logic [4:0]  idx;
        logic [14:0] mag;
        idx    = p[14] ? ~p[13:9] : p[13:9];
        mag    = iq_demod_pkg::SIN_QTR[idx];
        sin_of = p[15] ? -$signed(mag) : $signed(mag);
    endfunction

    // Mapped register word addresses
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = a inside {iq_demod_pkg::CTRL_OFS, iq_demod_pkg::DCOFS_OFS,
                            iq_demod_pkg::FREQ_OFS, iq_demod_pkg::CADDR_OFS,
                            iq_demod_pkg::CDATA_OFS, iq_demod_pkg::LMAP_OFS,
                            iq_demod_pkg::STAT_OFS, iq_demod_pkg::PROBE_OFS};
    endfunction

    // Factor clamped to 1..MAX_M so a bad write cannot overrun the taps
    function automatic logic [5:0] eff_m(input logic [5:0] f);
        if (f == 6'h00) eff_m = 6'h01;
        else if (f > 6'(MAX_M)) eff_m = 6'(MAX_M);
        else eff_m = f;
    endfunction

    // Next-state logic
    always_comb begin : comb
        logic [5:0]         m;
        logic               keep;
        logic               pd;
        logic signed [14:0] cosv;
        logic signed [14:0] nsinv;
        logic signed [14:0] xdc;
        logic signed [29:0] prod;
        logic [1:0][15:0]   mixed;
        logic signed [16:0] pair;
        logic signed [30:0] tap;     // Full product, so no bits drop before the sum
        logic signed [39:0] acc;
        logic [15:0]        fir;
        logic [15:0]        word;
        logic [3:0]         sel;
        int                 idx;
        m     = '0;
        keep  = 1'b0;
        pd    = 1'b0;
        cosv  = '0;
        nsinv = '0;
        xdc   = '0;
        prod  = '0;
        mixed = '0;
        pair  = '0;
        tap   = '0;
        acc   = '0;
        fir   = '0;
        word  = '0;
        sel   = '0;
        idx   = 0;
        nxt_state = state_ff;

        m    = eff_m(state_ff.ctrl[iq_demod_pkg::CTRL_M_LSB +: iq_demod_pkg::M_W]);
        pd   = state_ff.ctrl[iq_demod_pkg::CTRL_PD];
        // One slot in M kept; decimator bypass keeps all
        keep = state_ff.ctrl[iq_demod_pkg::CTRL_DEC_BYP] || (state_ff.dcnt == 6'h00);
        cosv  = sin_of(state_ff.phase + 16'h4000);
        nsinv = -sin_of(state_ff.phase);

        // Datapath holds still while powered down, saving toggle power
        if (!pd) begin
            nxt_state.phase = state_ff.phase + state_ff.freq;
            nxt_state.dcnt  = (state_ff.dcnt >= m - 6'h01) ? 6'h00 :
                              state_ff.dcnt + 6'h01;
            for (int c = 0; c < iq_demod_pkg::NCH; c++) begin
                // Offset of the half this channel belongs to
                if (state_ff.ctrl[iq_demod_pkg::CTRL_DC_BYP])
                    xdc = 15'($signed(adc_i[c]));
                else
                    xdc = 15'($signed(adc_i[c])) -
                          15'($signed(state_ff.dcofs[c / iq_demod_pkg::HALF_CH]));
                // Mixer, or straight through on I with Q at zero
                if (state_ff.ctrl[iq_demod_pkg::CTRL_MIX_BYP]) begin
                    mixed[0] = 16'(xdc);
                    mixed[1] = 16'h0000;
                end else begin
                    prod     = xdc * cosv;
                    mixed[0] = prod[29:14];
                    prod     = xdc * nsinv;
                    mixed[1] = prod[29:14];
                end
                // Same taps and factor for I and Q keep them aligned
                for (int q = 0; q < 2; q++) begin
                    nxt_state.dly[q][c] = {state_ff.dly[q][c][TAPS-2:0], mixed[q]};
                    acc = '0;
                    // Folded pairs: 8M coefficients serve 16M taps
                    for (int k = 0; k < NCOEF; k++) begin
                        if (k < 8 * int'(m)) begin
                            idx  = 16 * int'(m) - 1 - k;
                            pair = 17'($signed(state_ff.dly[q][c][k])) +
                                   17'($signed(state_ff.dly[q][c][idx]));
                            tap  = pair * $signed(state_ff.coef[k]);
                            acc  = acc + 40'(tap);
                        end
                    end
                    fir = state_ff.ctrl[iq_demod_pkg::CTRL_DEC_BYP] ?
                          state_ff.dly[q][c][0] : acc[28:13];
                    if (keep)
                        nxt_state.hold[q][c] = fir;
                    if (c == 0)
                        nxt_state.probe[q*16 +: 16] = keep ? fir : 16'h0000;
                end
            end
        end

        // Serializer: a word per 32 clocks, one bit per two clocks
        nxt_state.bcnt = state_ff.bcnt + 5'h01;
        for (int n = 0; n < iq_demod_pkg::NCH; n++) begin
            sel = state_ff.lmap[n*4 +: 4];
            if (state_ff.ctrl[iq_demod_pkg::CTRL_BYP])
                word = 16'($signed(adc_i[n]));
            else if (pd)
                word = 16'h0000;
            else if (state_ff.ctrl[iq_demod_pkg::CTRL_MUX_BYP])
                word = state_ff.hold[0][n];
            else
                word = state_ff.hold[sel[3]][sel[2:0]];
            if (nxt_state.bcnt == 5'h00)
                nxt_state.shreg[n] = word;
            nxt_state.lane[n] = nxt_state.shreg[n][4'hF - nxt_state.bcnt[4:1]];
        end
        nxt_state.bclk = nxt_state.bcnt[0];
        nxt_state.fclk = ~nxt_state.bcnt[4];

        // APB: one wait state, answer registered
        nxt_state.pready  = 1'b0;
        nxt_state.pslverr = 1'b0;
        nxt_state.prdata  = 32'h0000_0000;
        if (psel_i && penable_i && !state_ff.pready) begin
            nxt_state.pready  = 1'b1;
            nxt_state.pslverr = !reg_hit(paddr_i);
            if (!pwrite_i) begin
                case (paddr_i)
                    iq_demod_pkg::CTRL_OFS:  nxt_state.prdata = 32'(state_ff.ctrl);
                    iq_demod_pkg::DCOFS_OFS: nxt_state.prdata = {2'b00, state_ff.dcofs[1],
                                                                 2'b00, state_ff.dcofs[0]};
                    iq_demod_pkg::FREQ_OFS:  nxt_state.prdata = 32'(state_ff.freq);
                    iq_demod_pkg::CADDR_OFS: nxt_state.prdata = 32'(state_ff.caddr);
                    iq_demod_pkg::CDATA_OFS: begin
                        if (32'(state_ff.caddr) < NCOEF)
                            nxt_state.prdata = 32'(state_ff.coef[state_ff.caddr]);
                    end
                    iq_demod_pkg::LMAP_OFS:  nxt_state.prdata = state_ff.lmap;
                    iq_demod_pkg::STAT_OFS:  nxt_state.prdata = {10'h000, state_ff.dcnt,
                                                                 state_ff.phase};
                    iq_demod_pkg::PROBE_OFS: nxt_state.prdata = state_ff.probe;
                    default:                 nxt_state.prdata = 32'h0000_0000;
                endcase
            end
        end
        // Write lands on the completing edge only
        if (psel_i && penable_i && state_ff.pready && pwrite_i) begin
            case (paddr_i)
                iq_demod_pkg::CTRL_OFS:  nxt_state.ctrl = pwdata_i[13:0];
                iq_demod_pkg::DCOFS_OFS: begin
                    nxt_state.dcofs[0] = pwdata_i[13:0];
                    nxt_state.dcofs[1] = pwdata_i[29:16];
                end
                iq_demod_pkg::FREQ_OFS:  nxt_state.freq = pwdata_i[15:0];
                iq_demod_pkg::CADDR_OFS: nxt_state.caddr = pwdata_i[7:0];
                iq_demod_pkg::CDATA_OFS: begin
                    // Pointer steps so a bank loads in one burst
                    if (32'(state_ff.caddr) < NCOEF)
                        nxt_state.coef[state_ff.caddr] = pwdata_i[13:0];
                    nxt_state.caddr = state_ff.caddr + 8'h01;
                end
                iq_demod_pkg::LMAP_OFS:  nxt_state.lmap = pwdata_i;
                default:                 nxt_state.lmap = state_ff.lmap;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff      <= '0;
            state_ff.ctrl <= iq_demod_pkg::CTRL_RST;
            state_ff.lmap <= iq_demod_pkg::LMAP_RST;
            state_ff.freq <= iq_demod_pkg::FREQ_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flops
    assign prdata_o    = state_ff.prdata;
    assign pready_o    = state_ff.pready;
    assign pslverr_o   = state_ff.pslverr;
    assign lane_o      = state_ff.lane;
    assign frame_clk_o = state_ff.fclk;
    assign bit_clk_o   = state_ff.bclk;
endmodule // iq_demod_top

// ==== shared/iq_demod_pkg.sv ====
// Constants shared by the I/Q demodulator and decimator
package iq_demod_pkg;
    localparam int NCH         = 8;    // Converter channels
    localparam int HALF_CH     = 4;    // Channels in each demodulator half
    localparam int SMP_W       = 14;   // Converter sample width
    localparam int MIX_W       = 15;   // Mixing value: sign plus 14 magnitude bits
    localparam int PH_W        = 16;   // Phase step is sample rate over 2**16
    localparam int COEF_W      = 14;   // Stored coefficient width
    localparam int WORD_W      = 16;   // Output word width
    localparam int TAPS_PER_M  = 16;   // Filter taps per unit of decimation
    localparam int COEFS_PER_M = 8;    // Stored coefficients per unit of decimation
    localparam int ADDR_W      = 8;    // APB byte address width
    localparam int M_W         = 6;    // Decimation factor field width
    localparam int FRAME_CYC   = 32;   // One word: 16 bits of two clocks each

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] DCOFS_OFS = 8'h04;
    localparam logic [7:0] FREQ_OFS  = 8'h08;
    localparam logic [7:0] CADDR_OFS = 8'h0C;
    localparam logic [7:0] CDATA_OFS = 8'h10;
    localparam logic [7:0] LMAP_OFS  = 8'h14;
    localparam logic [7:0] STAT_OFS  = 8'h18;
    localparam logic [7:0] PROBE_OFS = 8'h1C;

    // Control field positions
    localparam int CTRL_BYP     = 0;   // Whole demodulator bypassed
    localparam int CTRL_PD      = 1;   // Demodulator powered down
    localparam int CTRL_DC_BYP  = 2;
    localparam int CTRL_MIX_BYP = 3;
    localparam int CTRL_DEC_BYP = 4;
    localparam int CTRL_MUX_BYP = 5;
    localparam int CTRL_M_LSB   = 8;

    // Values after reset
    localparam logic [13:0] CTRL_RST  = 14'h0100;       // Factor 1, all stages on
    localparam logic [31:0] LMAP_RST  = 32'h7654_3210;  // Lane n carries channel n I
    localparam logic [15:0] FREQ_RST  = 16'h0000;

    // Quarter sine at mid points of 32 steps, full scale 16383
    localparam logic [31:0][14:0] SIN_QTR = {
        15'h3FFA, 15'h3FD3, 15'h3F84, 15'h3F0E, 15'h3E71, 15'h3DAD, 15'h3CC4, 15'h3BB5,
        15'h3A81, 15'h392A, 15'h37AF, 15'h3611, 15'h3452, 15'h3273, 15'h3075, 15'h2E59,
        15'h2C21, 15'h29CD, 15'h275F, 15'h24D9, 15'h223D, 15'h1F8B, 15'h1CC6, 15'h19EF,
        15'h1708, 15'h1413, 15'h1111, 15'h0E05, 15'h0AF1, 15'h07D5, 15'h04B5, 15'h0192};
endpackage

// ==== verif/iq_demod_properties.sv ====
// Checker of bus handshake and serial framing at the demodulator top ports
module iq_demod_properties #(
    parameter int MAX_M = 4             // Same factor limit as the design
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [7:0]  lane_o,
    input wire logic        frame_clk_o,
    input wire logic        bit_clk_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Serial timing: bit clock is half rate, data settles before its rise
    property p_bit_toggle; 1'b1 |=> bit_clk_o != $past(bit_clk_o); endproperty
    // First edge after reset skipped: lanes stay at their reset level until the first word loads
    property p_lane_hold; bit_clk_o && $past(rst_n_i) |-> $stable(lane_o); endproperty
    property p_frame_fall; $fell(frame_clk_o) |-> !bit_clk_o ##16 $rose(frame_clk_o); endproperty
    // Register access: one wait state, answer stands one cycle
    property p_ready_lat; psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o; endproperty
    property p_ready_pulse; pready_o |=> !pready_o; endproperty
    property p_ready_access; pready_o |-> psel_i && penable_i; endproperty
    property p_err_addr;
        pready_o && paddr_i[1:0] == 2'h0 |-> pslverr_o == (paddr_i > iq_demod_pkg::PROBE_OFS);
    endproperty
    property p_rdata_idle; !pready_o |-> prdata_o == 32'h0; endproperty

    a_bit_toggle: assert property (p_bit_toggle)
        else $error("bit clock did not toggle");
    a_lane_hold: assert property (p_lane_hold)
        else $error("lane changed while bit clock high");
    a_frame_fall: assert property (p_frame_fall)
        else $error("frame clock period wrong");
    a_ready_lat: assert property (p_ready_lat)
        else $error("ready latency wrong");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (p_ready_access)
        else $error("ready outside access phase");
    a_err_addr: assert property (p_err_addr)
        else $error("slave error does not match address");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside answer cycle");

    c_err: cover property (pready_o && pslverr_o);
    c_read: cover property (pready_o && prdata_o != 32'h0);
    c_frame: cover property ($fell(frame_clk_o));
endmodule // iq_demod_properties

bind iq_demod_top iq_demod_properties #(.MAX_M(MAX_M)) i_iq_demod_properties (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .lane_o(lane_o), .frame_clk_o(frame_clk_o), .bit_clk_o(bit_clk_o));

// ==== verif/lane_rx_model.sv ====
// Receiver model: rebuilds each lane's 16-bit words from the serial stream
module lane_rx_model (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [7:0]       lane_i,
    input  wire logic             frame_clk_i,
    input  wire logic             bit_clk_i,
    output logic      [7:0][15:0] word_o,    // Last whole word per lane
    output logic      [15:0]      words_o    // Whole frames seen
);
    logic [7:0][15:0] sr;       // Shift registers, MSB first
    logic [4:0]       nbit;     // Bits taken in this frame
    logic             fr_prev;  // Frame clock at the previous bit
    logic             start;    // Frame clock rose: first bit of a word
    assign start = frame_clk_i && !fr_prev;
    // Take one bit while bit clock is high, where the data is settled
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {sr, word_o, words_o, nbit, fr_prev} <= '0;
        end else if (bit_clk_i) begin
            fr_prev <= frame_clk_i;
            nbit <= start ? 5'h01 : nbit + 5'h01;
            for (int n = 0; n < 8; n++) sr[n] <= {sr[n][14:0], lane_i[n]};
            // Sixteenth bit closes the word; partial words never count
            if (nbit == 5'h0F && !start) begin
                for (int n = 0; n < 8; n++) word_o[n] <= {sr[n][14:0], lane_i[n]};
                words_o <= words_o + 16'h0001;
            end
        end
    end
endmodule // lane_rx_model

// ==== verif/tb_top.sv ====
// Self-checking bench: registers over APB, lane words through the receiver
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk = 1'b0;    // 200 MHz sample clock
    logic             rst_n = 1'b0;  // Active-low reset
    logic [7:0][13:0] adc;           // Held samples per channel
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [7:0]       lane;
    logic             frame_clk;
    logic             bit_clk;
    logic [7:0][15:0] word;          // Words seen by the receiver
    logic [15:0]      words;
    logic [31:0]      rd;            // Last read data
    logic             er;            // Last slave error
    int               n_fail = 0;
    int               n_compared = 0;

    always #2.5 clk = ~clk;

    // Small factor limit keeps the filter short
    iq_demod_top #(.MAX_M(2)) i_iq_demod_top (.clk_i(clk), .rst_n_i(rst_n), .adc_i(adc),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .lane_o(lane), .frame_clk_o(frame_clk), .bit_clk_o(bit_clk));
    lane_rx_model i_lane_rx_model (.clk_i(clk), .rst_n_i(rst_n), .lane_i(lane),
        .frame_clk_i(frame_clk), .bit_clk_i(bit_clk), .word_o(word), .words_o(words));

    task automatic results();
        if (n_fail == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge; waits for ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) chk(32'h0, 32'h1);
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Let three fresh frames pass, then compare every lane
    task automatic lanes(input logic [7:0][15:0] e);
        logic [15:0] s;
        int          n;
        s = words;
        n = 0;
        while (words < s + 16'h0003 && n < 400) begin
            @(posedge clk);
            n++;
        end
        // Frames that never come count as a failure
        if (n >= 400) chk(32'h0, 32'h1);
        for (int k = 0; k < 8; k++) chk({16'h0, word[k]}, {16'h0, e[k]});
    endtask
    function automatic logic [15:0] sx(input logic [13:0] v);
        return {{2{v[13]}}, v};
    endfunction
    // Offset of half one is -16, of half two 0x123
    function automatic logic [15:0] dc(input int n);
        return sx(adc[n]) - sx(n < 4 ? 14'h3FF0 : 14'h0123);
    endfunction
    // Sample times a 15-bit mixing value, top 16 of the 30 product bits
    function automatic logic [15:0] mix(input logic [13:0] v, input logic signed [14:0] c);
        logic signed [29:0] p;
        p = $signed(v) * c;
        return p[29:14];
    endfunction

    initial begin
        logic [7:0][15:0] e;
        for (int n = 0; n < 8; n++) adc[n] = 14'h2000 ^ (14'h0413 * 14'(n));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(iq_demod_pkg::CTRL_OFS, 32'h100);
        chk({31'h0, er}, 32'h0);
        rd_chk(iq_demod_pkg::LMAP_OFS, 32'h7654_3210);
        rd_chk(iq_demod_pkg::DCOFS_OFS, 32'h0);
        rd_chk(8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        xfer(1'b1, iq_demod_pkg::FREQ_OFS, 32'h0001_ABCD);
        rd_chk(iq_demod_pkg::FREQ_OFS, 32'hABCD);
        // Coefficient pointer steps on each data write
        xfer(1'b1, iq_demod_pkg::CADDR_OFS, 32'h5);
        xfer(1'b1, iq_demod_pkg::CDATA_OFS, 32'hFFFF_FFFF);
        xfer(1'b1, iq_demod_pkg::CDATA_OFS, 32'h1234);
        rd_chk(iq_demod_pkg::CADDR_OFS, 32'h7);
        xfer(1'b1, iq_demod_pkg::CADDR_OFS, 32'h5);
        rd_chk(iq_demod_pkg::CDATA_OFS, 32'h3FFF);
        rd_chk(iq_demod_pkg::CADDR_OFS, 32'h5);
        // Whole bypass alone and over power-down, then every stage bypassed, then power-down alone
        for (int n = 0; n < 8; n++) e[n] = sx(adc[n]);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h101);
        lanes(e);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h103);
        lanes(e);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h13C);
        lanes(e);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h102);
        lanes('0);
        // Offset removal per half, later stages bypassed
        xfer(1'b1, iq_demod_pkg::DCOFS_OFS, 32'h0123_3FF0);
        for (int n = 0; n < 8; n++) e[n] = dc(n);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h138);
        lanes(e);
        // Reversed lane map, lane 0 carries an empty Q
        xfer(1'b1, iq_demod_pkg::LMAP_OFS, 32'h0123_456F);
        for (int n = 0; n < 8; n++) e[n] = n == 0 ? 16'h0 : dc(7 - n);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h118);
        lanes(e);
        // Factor two, outermost pair weighted one half: unity gain on steady input
        xfer(1'b1, iq_demod_pkg::CDATA_OFS, 32'h0);
        xfer(1'b1, iq_demod_pkg::CDATA_OFS, 32'h0);
        xfer(1'b1, iq_demod_pkg::CADDR_OFS, 32'h0);
        xfer(1'b1, iq_demod_pkg::CDATA_OFS, 32'h1000);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h22C);
        for (int n = 0; n < 8; n++) e[n] = sx(adc[n]);
        // Let the 32-tap delay lines fill with the new input
        repeat (40) @(posedge clk);
        lanes(e);
        // Reads an odd number of cycles apart: one kept slot, one empty slot
        xfer(1'b0, iq_demod_pkg::PROBE_OFS, 32'h0);
        e[0] = rd[15:0];
        e[1] = rd[31:16];
        @(posedge clk);
        xfer(1'b0, iq_demod_pkg::PROBE_OFS, 32'h0);
        chk(rd ^ {e[1], e[0]}, {16'h0, sx(adc[0])});
        // Mid-run reset clears the phase; with no step the mixer stays at phase zero
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(iq_demod_pkg::FREQ_OFS, 32'h0);
        xfer(1'b1, iq_demod_pkg::LMAP_OFS, 32'hFEDC_3210);
        xfer(1'b1, iq_demod_pkg::CTRL_OFS, 32'h114);
        // Lanes 0-3 carry I of channels 1-4, lanes 4-7 Q of channels 5-8
        for (int n = 0; n < 8; n++)
            e[n] = n < 4 ? mix(adc[n], iq_demod_pkg::SIN_QTR[31]) :
                           mix(adc[n], -$signed(iq_demod_pkg::SIN_QTR[0]));
        lanes(e);
        results();
    end

    // Watchdog at 4000 cycles, well beyond the fewer than a thousand cycles the run needs
    initial begin
        #20000;
        $display("[ERR] %0t watchdog expired", $time);
        n_fail++;
        results();
    end
endmodule // tb_top
